// ===== mpo_slice.sv
`timescale 1ns/1ps
`default_nettype none
module mpo_slice
  import mpo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpo_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [mpo_pkg::PRE_W-1:0] module_prescale,
  input wire logic [2:0][mpo_pkg::CMP_W-1:0] timer_value,
  input wire logic [2:0][mpo_pkg::CMP_W-1:0] timer_period,
  input wire logic [2:0] timer_down,
  input wire logic [2:0] timer_tick_clock,
  input wire logic [2:0] timer_sync_out,
  input wire logic [2:0] timer_sync_taken,
  input wire logic [2:0] external_sync_line,
  input wire logic [2:0] fault_trigger,
  output logic timer0_sync_in,
  output logic [1:0] op1_timing_source,
  output logic [1:0] op2_timing_source,
  output logic gen0_output_a,
  output logic gen0_output_b
);
  typedef struct packed {
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic [31:0] prdata;
    logic pslverr;
    logic [PRE_W-1:0] mod_cnt;
    logic [TSEL_W-1:0] tsel;
    logic [7:0] upm_ab;
    logic [TRIG_W-1:0] trig;
    logic [FORCE_W-1:0] force_cfg;
    logic [DT_W-1:0] dt;
    logic [CAR_W-1:0] car;
    logic [1:0] tog_last;
    logic sync_out;
    logic out_a;
    logic out_b;
    logic dta_out;
    logic [DLY_W-1:0] dta_cnt;
    logic dtb_out;
    logic [DLY_W-1:0] dtb_cnt;
  } mpo_state_s;

  mpo_state_s s;
  mpo_state_s next_s;

  function automatic logic [1:0] timer_index(input logic [1:0] code);
    // code 3 is not defined; it falls back to timer 0
    return (code > 2'h2) ? 2'h0 : code;
  endfunction

  function automatic logic trig_source(input logic [2:0] code, input logic [2:0] faults,
                                       input logic sync_ev);
    if (code < TRIG_SYNC) begin
      return faults[code[1:0]];
    end
    return (code == TRIG_SYNC) ? sync_ev : 1'b0;
  endfunction

  function automatic logic apply_action(input logic cur, input logic [1:0] code);
    case (code)
      ACT_LOW: return 1'b0;
      ACT_HIGH: return 1'b1;
      ACT_TOGGLE: return ~cur;
      default: return cur;
    endcase
  endfunction

  // later events in the list win when several land in one cycle
  function automatic logic gen_step(input logic cur, input logic [11:0] acts,
                                    input logic [5:0] evs, input logic shot_ev,
                                    input logic [1:0] shot_lvl, input logic [1:0] cont);
    logic v;
    v = cur;
    for (int i = 0; i < 6; i++) begin
      if (evs[i]) begin
        v = apply_action(v, acts[2*i +: 2]);
      end
    end
    if (shot_ev && (shot_lvl == ACT_LOW || shot_lvl == ACT_HIGH)) begin
      v = (shot_lvl == ACT_HIGH);
    end
    if (cont == ACT_LOW || cont == ACT_HIGH) begin
      v = (cont == ACT_HIGH);
    end
    return v;
  endfunction

  // returns {out, count}; an edge is passed once the count reaches its delay
  function automatic logic [DLY_W:0] edge_step(input logic in, input logic out,
                                               input logic [DLY_W-1:0] cnt, input logic tick,
                                               input logic [DLY_W-1:0] rise_d,
                                               input logic [DLY_W-1:0] fall_d,
                                               input logic use_rise, input logic use_fall);
    logic [DLY_W-1:0] lim;
    logic use_d;
    lim = in ? rise_d : fall_d;
    use_d = in ? use_rise : use_fall;
    if (in == out) begin
      return {out, {DLY_W{1'b0}}};
    end
    if (!use_d || cnt >= lim) begin
      return {in, {DLY_W{1'b0}}};
    end
    return {out, tick ? cnt + 16'h1 : cnt};
  endfunction

  logic mod_tick;
  logic [1:0] tidx;
  logic [CMP_W-1:0] tval;
  logic tick;
  logic sync_ev;
  logic zero_ev;
  logic period_ev;
  logic cmp_a_ev;
  logic cmp_b_ev;
  logic t0_ev;
  logic t1_ev;
  logic [2:0] ev3;
  logic [4:0] ev5;
  logic [5:0] evs;
  logic dtick;
  logic wr;
  logic [ADDR_W-1:0] waddr;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_act_a;
  logic wr_act_b;
  logic wr_force;
  logic wr_fed;
  logic wr_red;
  logic [2:0] ssel;
  logic [CMP_W-1:0] cmp_a_sh;
  logic [CMP_W-1:0] cmp_a;
  logic [CMP_W-1:0] cmp_b_sh;
  logic [CMP_W-1:0] cmp_b;
  logic pend_a;
  logic pend_b;
  logic [ACT_W-1:0] act_a_sh;
  logic [ACT_W-1:0] act_a;
  logic [ACT_W-1:0] act_b_sh;
  logic [ACT_W-1:0] act_b;
  logic [3:0] cont;
  logic [DLY_W-1:0] fed_sh;
  logic [DLY_W-1:0] fed;
  logic [DLY_W-1:0] red_sh;
  logic [DLY_W-1:0] rising_edge_delay;
  logic [1:0] car_out;

  assign wr = psel && penable && pwrite;
  assign waddr = paddr;
  assign wr_cmp_a = wr && waddr == OFF_COMPARE_A;
  assign wr_cmp_b = wr && waddr == OFF_COMPARE_B;
  assign wr_act_a = wr && waddr == OFF_OUT_A_ACTIONS;
  assign wr_act_b = wr && waddr == OFF_OUT_B_ACTIONS;
  assign wr_force = wr && waddr == OFF_SOFTWARE_FORCE;
  assign wr_fed = wr && waddr == OFF_FALL_DELAY;
  assign wr_red = wr && waddr == OFF_RISE_DELAY;

  // the base tick is one system cycle; the printed base is slightly longer
  assign mod_tick = (s.mod_cnt == module_prescale);
  assign tidx = timer_index(s.tsel[OP0_LSB +: 2]);
  assign tval = timer_value[tidx];
  assign tick = timer_tick_clock[tidx];
  assign sync_ev = timer_sync_taken[tidx];
  // zero, period and compare events are qualified by the timer tick so a held count fires only once
  assign zero_ev = tick && tval == '0;
  assign period_ev = tick && tval == timer_period[tidx];
  assign cmp_a_ev = tick && tval == cmp_a;
  assign cmp_b_ev = tick && tval == cmp_b;
  assign t0_ev = trig_source(s.trig[T0_SEL_LSB +: 3], fault_trigger, sync_ev);
  assign t1_ev = trig_source(s.trig[T1_SEL_LSB +: 3], fault_trigger, sync_ev);
  assign ev3 = {sync_ev, period_ev, zero_ev};
  assign ev5 = {sync_ev, cmp_b_ev, cmp_a_ev, period_ev, zero_ev};
  assign evs = {t1_ev, t0_ev, cmp_b_ev, cmp_a_ev, period_ev, zero_ev};
  assign dtick = s.dt[DT_CLKSEL_BIT] ? tick : mod_tick;
  assign ssel = s.tsel[SYNCSEL_LSB +: 3];

  mpo_shadow #(.W(CMP_W), .MW(UPM_W)) u_cmp_a (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_cmp_a), .wdata(pwdata[CMP_W-1:0]),
    .method(s.upm_ab[UPM_A_LSB +: UPM_W]), .events(ev3),
    .shadow(cmp_a_sh), .active(cmp_a), .pending(pend_a));
  mpo_shadow #(.W(CMP_W), .MW(UPM_W)) u_cmp_b (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_cmp_b), .wdata(pwdata[CMP_W-1:0]),
    .method(s.upm_ab[UPM_B_LSB +: UPM_W]), .events(ev3),
    .shadow(cmp_b_sh), .active(cmp_b), .pending(pend_b));
  mpo_shadow #(.W(ACT_W), .MW(UPM_W)) u_act_a (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_act_a), .wdata(pwdata[ACT_W-1:0]),
    .method(s.trig[CFG_UPM_LSB +: UPM_W]), .events(ev3),
    .shadow(act_a_sh), .active(act_a), .pending());
  mpo_shadow #(.W(ACT_W), .MW(UPM_W)) u_act_b (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_act_b), .wdata(pwdata[ACT_W-1:0]),
    .method(s.trig[CFG_UPM_LSB +: UPM_W]), .events(ev3),
    .shadow(act_b_sh), .active(act_b), .pending());
  mpo_shadow #(.W(4), .MW(FUPM_W)) u_cont (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_force), .wdata(pwdata[CONT_A_LSB +: 4]),
    .method(s.force_cfg[CONT_UPM_LSB +: FUPM_W]), .events(ev5),
    .shadow(), .active(cont), .pending());
  mpo_shadow #(.W(DLY_W), .MW(UPM_W)) u_fed (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_fed), .wdata(pwdata[DLY_W-1:0]),
    .method(s.dt[FED_UPM_LSB +: UPM_W]), .events(ev3),
    .shadow(fed_sh), .active(fed), .pending());
  mpo_shadow #(.W(DLY_W), .MW(UPM_W)) u_red (
    .sys_clk(sys_clk), .rst(rst), .wr(wr_red), .wdata(pwdata[DLY_W-1:0]),
    .method(s.dt[RED_UPM_LSB +: UPM_W]), .events(ev3),
    .shadow(red_sh), .active(rising_edge_delay), .pending());

  mpo_carrier u_carrier (
    .sys_clk(sys_clk), .rst(rst), .mod_tick(mod_tick), .cfg(s.car),
    .in_ab({s.dtb_out, s.dta_out}), .out_ab(car_out));

  always_comb begin
    next_s = s;
    next_s.ext_s1 = external_sync_line;
    next_s.ext_s2 = s.ext_s1;
    next_s.mod_cnt = mod_tick ? '0 : s.mod_cnt + 8'h1;
    if (ssel >= SYNC_TIMER_FIRST && ssel <= SYNC_TIMER_LAST) begin
      next_s.sync_out = timer_sync_out[2'(ssel - SYNC_TIMER_FIRST)];
    end else if (ssel >= SYNC_EXT_FIRST && ssel <= SYNC_EXT_LAST) begin
      next_s.sync_out = s.ext_s2[2'(ssel - SYNC_EXT_FIRST)];
    end else begin
      next_s.sync_out = 1'b0;
    end
    // a toggle of the one-shot bit is one force event
    next_s.tog_last = {s.force_cfg[TOG_B_BIT], s.force_cfg[TOG_A_BIT]};
    next_s.out_a = gen_step(s.out_a, timer_down[tidx] ? act_a[23:12] : act_a[11:0], evs,
                            s.force_cfg[TOG_A_BIT] != s.tog_last[0],
                            s.force_cfg[SHOT_A_LSB +: 2], cont[1:0]);
    next_s.out_b = gen_step(s.out_b, timer_down[tidx] ? act_b[23:12] : act_b[11:0], evs,
                            s.force_cfg[TOG_B_BIT] != s.tog_last[1],
                            s.force_cfg[SHOT_B_LSB +: 2], cont[3:2]);
    // A takes the rise delay only in split mode; B always takes the fall delay
    {next_s.dta_out, next_s.dta_cnt} = edge_step(s.out_a, s.dta_out, s.dta_cnt, dtick,
                                                 rising_edge_delay, fed, !s.dt[DEB_MODE_BIT], 1'b0);
    {next_s.dtb_out, next_s.dtb_cnt} = edge_step(s.out_b, s.dtb_out, s.dtb_cnt, dtick,
                                                 rising_edge_delay, fed, s.dt[DEB_MODE_BIT], 1'b1);
    // register writes at the access edge
    if (wr) begin
      case (waddr)
        OFF_TIMER_SELECT: next_s.tsel = pwdata[TSEL_W-1:0];
        OFF_STAMP_CONFIG: next_s.upm_ab = pwdata[7:0];
        OFF_TRIGGER_CONFIG: next_s.trig = pwdata[TRIG_W-1:0];
        OFF_SOFTWARE_FORCE: next_s.force_cfg = pwdata[FORCE_W-1:0];
        OFF_DEADBAND_CONFIG: next_s.dt = pwdata[DT_W-1:0];
        OFF_CARRIER_CONFIG: next_s.car = pwdata[CAR_W-1:0];
        default: next_s.tsel = s.tsel;
      endcase
    end
    // read data is captured in the setup cycle so prdata comes from a flop
    if (psel && !penable) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      case (paddr)
        OFF_TIMER_SELECT: next_s.prdata = 32'(s.tsel);
        OFF_STAMP_CONFIG: next_s.prdata = 32'({pend_b, pend_a, s.upm_ab});
        OFF_COMPARE_A: next_s.prdata = 32'(cmp_a_sh);
        OFF_COMPARE_B: next_s.prdata = 32'(cmp_b_sh);
        OFF_TRIGGER_CONFIG: next_s.prdata = 32'(s.trig);
        OFF_SOFTWARE_FORCE: next_s.prdata = 32'(s.force_cfg);
        OFF_OUT_A_ACTIONS: next_s.prdata = 32'(act_a_sh);
        OFF_OUT_B_ACTIONS: next_s.prdata = 32'(act_b_sh);
        OFF_DEADBAND_CONFIG: next_s.prdata = 32'(s.dt);
        OFF_FALL_DELAY: next_s.prdata = 32'(fed_sh);
        OFF_RISE_DELAY: next_s.prdata = 32'(red_sh);
        OFF_CARRIER_CONFIG: next_s.prdata = 32'(s.car);
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.dt <= DT_CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && s.pslverr;
  assign timer0_sync_in = s.sync_out;
  assign op1_timing_source = s.tsel[OP1_LSB +: 2];
  assign op2_timing_source = s.tsel[OP2_LSB +: 2];
  assign gen0_output_a = car_out[0];
  assign gen0_output_b = car_out[1];
endmodule
`default_nettype wire

// ===== mpo_pkg.sv
package mpo_pkg;
  localparam int CMP_W = 16;
  localparam int DLY_W = 16;
  localparam int ACT_W = 24;
  localparam int UPM_W = 4;
  localparam int FUPM_W = 6;
  localparam int PRE_W = 8;
  localparam int CPRE_W = 4;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TIMER_SELECT = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_STAMP_CONFIG = 12'h03c;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_A = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_B = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER_CONFIG = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_SOFTWARE_FORCE = 12'h04c;
  localparam logic [ADDR_W-1:0] OFF_OUT_A_ACTIONS = 12'h050;
  localparam logic [ADDR_W-1:0] OFF_OUT_B_ACTIONS = 12'h054;
  localparam logic [ADDR_W-1:0] OFF_DEADBAND_CONFIG = 12'h058;
  localparam logic [ADDR_W-1:0] OFF_FALL_DELAY = 12'h05c;
  localparam logic [ADDR_W-1:0] OFF_RISE_DELAY = 12'h060;
  localparam logic [ADDR_W-1:0] OFF_CARRIER_CONFIG = 12'h064;
  // operator_timer_select fields
  localparam int TSEL_W = 9;
  localparam int OP0_LSB = 0;
  localparam int OP1_LSB = 2;
  localparam int OP2_LSB = 4;
  localparam int SYNCSEL_LSB = 6;
  // stamp config fields
  localparam int UPM_A_LSB = 0;
  localparam int UPM_B_LSB = 4;
  localparam int PEND_A_BIT = 8;
  localparam int PEND_B_BIT = 9;
  // trigger config fields
  localparam int TRIG_W = 10;
  localparam int CFG_UPM_LSB = 0;
  localparam int T0_SEL_LSB = 4;
  localparam int T1_SEL_LSB = 7;
  // software force fields
  localparam int FORCE_W = 16;
  localparam int CONT_UPM_LSB = 0;
  localparam int CONT_A_LSB = 6;
  localparam int CONT_B_LSB = 8;
  localparam int TOG_A_BIT = 10;
  localparam int SHOT_A_LSB = 11;
  localparam int TOG_B_BIT = 13;
  localparam int SHOT_B_LSB = 14;
  // deadband config fields
  localparam int DT_W = 18;
  localparam int FED_UPM_LSB = 0;
  localparam int RED_UPM_LSB = 4;
  localparam int DEB_MODE_BIT = 8;
  localparam int DT_CLKSEL_BIT = 17;
  localparam logic [DT_W-1:0] DT_CFG_RST = 18'h18000;
  // carrier config fields
  localparam int CAR_W = 14;
  localparam int CAR_EN_BIT = 0;
  localparam int CAR_PRE_LSB = 1;
  localparam int CAR_DUTY_LSB = 5;
  localparam int CAR_OSH_LSB = 8;
  localparam int CAR_OUTINV_BIT = 12;
  localparam int CAR_ININV_BIT = 13;
  // trigger source codes
  localparam logic [2:0] TRIG_SYNC = 3'h3;
  // action and force codes
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // sync select codes
  localparam logic [2:0] SYNC_TIMER_FIRST = 3'h1;
  localparam logic [2:0] SYNC_TIMER_LAST = 3'h3;
  localparam logic [2:0] SYNC_EXT_FIRST = 3'h4;
  localparam logic [2:0] SYNC_EXT_LAST = 3'h6;
  // module clock base period vs system clock
  localparam int MOD_BASE_PERIOD_PS = 6250;
  localparam int SYS_PERIOD_PS = 5000;
  localparam int MOD_BASE_CYCLES = (MOD_BASE_PERIOD_PS / SYS_PERIOD_PS) < 1 ? 1 :
                                   (MOD_BASE_PERIOD_PS / SYS_PERIOD_PS);
endpackage

// ===== mpo_shadow.sv
`timescale 1ns/1ps
`default_nettype none
module mpo_shadow #(
  parameter int W = 16,
  parameter int MW = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic [MW-1:0] method,
  input wire logic [MW-2:0] events,
  output logic [W-1:0] shadow,
  output logic [W-1:0] active,
  output logic pending
);
  typedef struct packed {
    logic [W-1:0] shadow;
    logic [W-1:0] active;
    logic pending;
  } mpo_shadow_s;

  mpo_shadow_s s;
  mpo_shadow_s next_s;

  always_comb begin
    next_s = s;
    // all-zero method transfers on the next edge; top bit blocks any transfer
    if (s.pending && (method == '0 ||
        (!method[MW-1] && |(method[MW-2:0] & events)))) begin
      next_s.active = s.shadow;
      next_s.pending = 1'b0;
    end
    // a new write wins over a transfer in the same cycle so nothing is lost
    if (wr) begin
      next_s.shadow = wdata;
      next_s.pending = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign shadow = s.shadow;
  assign active = s.active;
  assign pending = s.pending;
endmodule
`default_nettype wire

// ===== mpo_carrier.sv
`timescale 1ns/1ps
`default_nettype none
module mpo_carrier
  import mpo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mod_tick,
  input wire logic [mpo_pkg::CAR_W-1:0] cfg,
  input wire logic [1:0] in_ab,
  output logic [1:0] out_ab
);
  typedef struct packed {
    logic [CPRE_W-1:0] pre_cnt;
    logic [2:0] phase;
    logic [1:0] in_last;
    logic [1:0][3:0] shot;
    logic [1:0] out;
  } mpo_carrier_s;

  mpo_carrier_s s;
  mpo_carrier_s next_s;
  logic ctick;
  logic [1:0] src;
  logic carrier_hi;

  always_comb begin
    next_s = s;
    ctick = mod_tick && (s.pre_cnt == cfg[CAR_PRE_LSB +: CPRE_W]);
    if (mod_tick) begin
      next_s.pre_cnt = ctick ? '0 : s.pre_cnt + 4'h1;
    end
    if (ctick) begin
      next_s.phase = s.phase + 3'h1;
    end
    carrier_hi = ({1'b0, s.phase} < {1'b0, cfg[CAR_DUTY_LSB +: 3]});
    src = cfg[CAR_ININV_BIT] ? ~in_ab : in_ab;
    next_s.in_last = src;
    for (int i = 0; i < 2; i++) begin
      if (src[i] && !s.in_last[i]) begin
        next_s.shot[i] = cfg[CAR_OSH_LSB +: 4];
      end else if (ctick && s.shot[i] != '0) begin
        next_s.shot[i] = s.shot[i] - 4'h1;
      end
      if (cfg[CAR_EN_BIT]) begin
        next_s.out[i] = (src[i] && (s.shot[i] != '0 || carrier_hi)) ^ cfg[CAR_OUTINV_BIT];
      end else begin
        next_s.out[i] = in_ab[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_ab = s.out;
endmodule
`default_nettype wire

// ===== mpo_slice_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mpo_slice_chk
  import mpo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mpo_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] timer_sync_out,
  input wire logic [2:0] external_sync_line,
  input wire logic timer0_sync_in,
  input wire logic [1:0] op1_timing_source,
  input wire logic [1:0] op2_timing_source,
  input wire logic gen0_output_a,
  input wire logic gen0_output_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = paddr >= OFF_TIMER_SELECT && paddr <= OFF_CARRIER_CONFIG && paddr[1:0] == 2'h0;
  sequence acc_s;
    psel && penable;
  endsequence
  sequence sel_wr_s;
    acc_s ##0 pwrite && paddr == OFF_TIMER_SELECT;
  endsequence
  apb_ready_a: assert property (acc_s |-> pready)
    else $error("no ready in access");
  miss_err_a: assert property (acc_s ##0 !hit |-> pslverr)
    else $error("unmapped access without error");
  hit_ok_a: assert property (acc_s ##0 hit |-> !pslverr)
    else $error("mapped access with error");
  err_data_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read data not zero");
  sync_src_a: assert property (timer0_sync_in |-> $past(|timer_sync_out) ||
    $past(|external_sync_line, 2) || $past(|external_sync_line, 3) ||
    $past(|external_sync_line, 4)) else $error("sync without source");
  tsel_wr_a: assert property (sel_wr_s |=> op1_timing_source == $past(pwdata[3:2]) &&
    op2_timing_source == $past(pwdata[5:4])) else $error("timer select not written");
  tsel_hold_a: assert property (!$stable({op1_timing_source, op2_timing_source}) |->
    $past(psel && penable && pwrite && paddr == OFF_TIMER_SELECT))
    else $error("timer select changed without write");
  reset_out_a: assert property ($past(rst) |-> !gen0_output_a && !gen0_output_b &&
    op1_timing_source == 2'h0) else $error("outputs not cleared by reset");
endmodule
bind mpo_slice mpo_slice_chk u_chk(.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_sync_out(timer_sync_out),
  .external_sync_line(external_sync_line), .timer0_sync_in(timer0_sync_in),
  .op1_timing_source(op1_timing_source), .op2_timing_source(op2_timing_source),
  .gen0_output_a(gen0_output_a), .gen0_output_b(gen0_output_b));
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mpo_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err_q, hitf;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_q;
  logic pready, pslverr, sync_in, out_a, out_b;
  logic [1:0] op1, op2;
  logic [PRE_W-1:0] module_prescale = '0;
  logic [2:0][CMP_W-1:0] tval = '0, tper = '0;
  logic [2:0] tdown = '0, ttick = '0, tsync = '0, ttaken = '0, ext = '0, fault = '0;
  int fails = 0, compares = 0, cyc = 0, c;
  mpo_slice u_mpo_slice(.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_prescale(module_prescale), .timer_value(tval),
    .timer_period(tper), .timer_down(tdown), .timer_tick_clock(ttick),
    .timer_sync_out(tsync), .timer_sync_taken(ttaken), .external_sync_line(ext),
    .fault_trigger(fault), .timer0_sync_in(sync_in), .op1_timing_source(op1),
    .op2_timing_source(op2), .gen0_output_a(out_a), .gen0_output_b(out_b));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic final_report();
    $display("errors %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a hung handshake would otherwise stall the run forever
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    xfer(a, 1'b0, 32'h0);
    chk(rd_q, e);
    chk({31'h0, err_q}, {31'h0, er});
  endtask
  // one timer 0 count tick at value v
  task automatic tick0(input logic [15:0] v);
    tval[0] <= v;
    ttick[0] <= 1'b1;
    @(posedge sys_clk);
    ttick[0] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic pins(input logic ea, input logic eb);
    repeat (6) @(posedge sys_clk);
    chk({31'h0, out_a}, {31'h0, ea});
    chk({31'h0, out_b}, {31'h0, eb});
  endtask
  initial begin
    tper[0] = 16'h00ff;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(OFF_DEADBAND_CONFIG, 32'h18000, 1'b0);
    rd(OFF_STAMP_CONFIG, 32'h0, 1'b0);
    rd(12'h068, 32'h0, 1'b1);
    rd(12'h000, 32'h0, 1'b1);
    for (c = 0; c < 8; c++) begin
      wr(OFF_TIMER_SELECT, 32'(c << 6));
      tsync <= (c == 0 || c == 7) ? 3'h7 : (c < 4 ? 3'(1 << (c - 1)) : 3'h0);
      ext <= (c == 0 || c == 7) ? 3'h7 : (c > 3 ? 3'(1 << (c - 4)) : 3'h0);
      @(posedge sys_clk);
      tsync <= '0;
      ext <= '0;
      hitf = 1'b0;
      repeat (6) begin
        @(posedge sys_clk);
        hitf |= sync_in;
      end
      chk({31'h0, hitf}, 32'(c > 0 && c < 7));
    end
    wr(OFF_TIMER_SELECT, 32'h18);
    chk({30'h0, op1, op2}, 32'h9);
    rd(OFF_TIMER_SELECT, 32'h18, 1'b0);
    wr(OFF_STAMP_CONFIG, 32'h8);
    wr(OFF_COMPARE_A, 32'h10);
    rd(OFF_STAMP_CONFIG, 32'h108, 1'b0);
    rd(OFF_COMPARE_A, 32'h10, 1'b0);
    tick0(16'h0);
    rd(OFF_STAMP_CONFIG, 32'h108, 1'b0);
    wr(OFF_STAMP_CONFIG, 32'h1);
    tick0(16'h10);
    rd(OFF_STAMP_CONFIG, 32'h101, 1'b0);
    tick0(16'h0);
    rd(OFF_STAMP_CONFIG, 32'h1, 1'b0);
    wr(OFF_OUT_A_ACTIONS, 32'h30021);
    tick0(16'h10);
    pins(1'b1, 1'b0);
    tdown[0] <= 1'b1;
    tick0(16'h10);
    pins(1'b0, 1'b0);
    tdown[0] <= 1'b0;
    wr(OFF_OUT_B_ACTIONS, 32'h20);
    tick0(16'h10);
    pins(1'b1, 1'b1);
    wr(OFF_OUT_A_ACTIONS, 32'h201);
    for (c = 0; c < 5; c++) begin
      tick0(16'h0);
      wr(OFF_TRIGGER_CONFIG, 32'(c << 4));
      fault <= c < 3 ? 3'(1 << c) : (c == 4 ? 3'h7 : 3'h0);
      ttaken <= c == 3 ? 3'h1 : (c == 4 ? 3'h7 : 3'h0);
      @(posedge sys_clk);
      fault <= '0;
      ttaken <= '0;
      pins(c < 4, 1'b1);
    end
    wr(OFF_SOFTWARE_FORCE, 32'h1400);
    pins(1'b1, 1'b1);
    wr(OFF_SOFTWARE_FORCE, 32'h1540);
    pins(1'b0, 1'b0);
    wr(OFF_SOFTWARE_FORCE, 32'h1240);
    pins(1'b0, 1'b1);
    // a fall delay of three ticks must hold B high past the undelayed latency
    wr(OFF_FALL_DELAY, 32'h3);
    rd(OFF_FALL_DELAY, 32'h3, 1'b0);
    wr(OFF_SOFTWARE_FORCE, 32'h1140);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, out_b}, 32'h1);
    pins(1'b0, 1'b0);
    // enabled carrier with zero duty and inverted outputs shows both pins high
    wr(OFF_CARRIER_CONFIG, 32'h1001);
    rd(OFF_CARRIER_CONFIG, 32'h1001, 1'b0);
    pins(1'b1, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
